// >>> mcpw_pkg.sv
// Shared constants and types for the six-channel motor control modulator.
package mcpw_pkg;
  localparam int unsigned CNT_W = 12;
  localparam int unsigned NCH = 6;
  localparam int unsigned NPAIR = 3;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned DT_W = 8;
  localparam int unsigned PDIV_W = 3;

  localparam logic [7:0] A_MAIN = 8'h20;
  localparam logic [7:0] A_SEC = 8'h21;
  localparam logic [7:0] A_FCTL = 8'h22;
  localparam logic [7:0] A_FSTAT = 8'h23;
  localparam logic [7:0] A_FACK = 8'h24;
  localparam logic [7:0] A_OVR = 8'h25;
  localparam logic [7:0] A_CNTH = 8'h26;
  localparam logic [7:0] A_CNTL = 8'h27;
  localparam logic [7:0] A_MODH = 8'h28;
  localparam logic [7:0] A_MODL = 8'h29;
  localparam logic [7:0] A_VAL0 = 8'h2A;
  localparam logic [7:0] A_VALN = 8'h35;
  localparam logic [7:0] A_DEAD = 8'h36;
  localparam logic [7:0] A_CFG = 8'h37;
  localparam logic [7:0] A_IST = 8'h38;
  localparam logic [7:0] A_IMSK = 8'h39;

  localparam int unsigned B_RUN = 0;
  localparam int unsigned B_PERMIT = 1;
  localparam int unsigned B_RFLAG = 4;
  localparam int unsigned B_RIE = 5;
  localparam int unsigned B_OVREN = 6;
  localparam int unsigned B_CORR = 2;
  localparam int unsigned B_F1MODE = 0;
  localparam int unsigned B_F1IE = 1;
  localparam int unsigned B_F4MODE = 6;
  localparam int unsigned B_F4IE = 7;
  localparam int unsigned B_F1ACK = 0;
  localparam int unsigned B_F4ACK = 6;
  localparam int unsigned B_CFG_INDEP = 0;
  localparam int unsigned B_CFG_CENTER = 1;
  localparam int unsigned B_CFG_NTOP = 2;
  localparam int unsigned B_CFG_NBOT = 3;
  localparam int unsigned B_CFG_ISENSE = 4;
  localparam int unsigned B_CFG_FP1 = 5;
  localparam int unsigned B_CFG_FP4 = 6;
  localparam int unsigned I_RELOAD = 0;
  localparam int unsigned I_FAULT1 = 1;
  localparam int unsigned I_FAULT4 = 2;

  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [15:0] RST_VAL = 16'h0000;
  localparam logic [CNT_W-1:0] RST_CNT = 12'h000;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } mcpw_bus_type;

  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } mcpw_dir_type;

  typedef enum logic [2:0] {
    DT_TOP = 3'b001,
    DT_BOT = 3'b010,
    DT_GAP = 3'b100
  } mcpw_dt_st_type;

  typedef struct packed {
    mcpw_dt_st_type st;
    logic [DT_W-1:0] cnt;
    logic top;
    logic bot;
  } mcpw_dt_state_type;

  typedef struct packed {
    logic run;
    logic permit;
    logic rflag;
    logic rie;
    logic [1:0] presc;
    logic [2:0] sw_corr;
    logic [7:0] fctl;
    logic [1:0] flat;
    logic [1:0] fhold;
    logic ovr_en;
    logic [5:0] ovr_lvl;
    logic [CNT_W-1:0] mod_buf;
    logic [CNT_W-1:0] mod_act;
    logic [NCH-1:0][15:0] val_buf;
    logic [NCH-1:0][15:0] val_act;
    logic [DT_W-1:0] dead;
    logic [7:0] cfg;
    logic [2:0] ist;
    logic [2:0] imask;
    logic [PDIV_W-1:0] pdiv;
    logic [CNT_W-1:0] cnt;
    mcpw_dir_type dir;
    logic [1:0] fs1;
    logic [1:0] fs2;
    logic [2:0] ss1;
    logic [2:0] ss2;
    logic [NCH-1:0] pwm;
    logic [7:0] rdata;
  } mcpw_state_type;
endpackage : mcpw_pkg

// >>> mcpw_dead.sv
// Dead-time inserter for one complementary output pair.
`timescale 1ns/1ps
module mcpw_dead (
  input wire logic mclk_i,
  input wire logic srst_i,
  input wire logic [mcpw_pkg::DT_W-1:0] dead_i,
  input wire logic raw_i,
  output logic top_o,
  output logic bot_o
);
  import mcpw_pkg::*;

  mcpw_dt_state_type s_r;
  mcpw_dt_state_type s_nxt;

  // Both switches stay off for exactly dead_i clock cycles after every
  // change of the raw waveform, so a top and bottom device never conduct
  // together. A raw pulse shorter than the dead time is swallowed.
  always_comb begin
    s_nxt = s_r;
    unique case (s_r.st)
      DT_TOP: begin
        if (!raw_i) begin
          s_nxt.top = 1'b0;
          if (dead_i == '0) begin
            s_nxt.bot = 1'b1;
            s_nxt.st = DT_BOT;
          end else begin
            s_nxt.cnt = dead_i - 1'b1;
            s_nxt.st = DT_GAP;
          end
        end
      end
      DT_BOT: begin
        if (raw_i) begin
          s_nxt.bot = 1'b0;
          if (dead_i == '0) begin
            s_nxt.top = 1'b1;
            s_nxt.st = DT_TOP;
          end else begin
            s_nxt.cnt = dead_i - 1'b1;
            s_nxt.st = DT_GAP;
          end
        end
      end
      DT_GAP: begin
        if (s_r.cnt != '0) begin
          s_nxt.cnt = s_r.cnt - 1'b1;
        end else begin
          s_nxt.top = raw_i;
          s_nxt.bot = !raw_i;
          s_nxt.st = raw_i ? DT_TOP : DT_BOT;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s_r <= '{st: DT_GAP, cnt: '0, top: 1'b0, bot: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign top_o = s_r.top;
  assign bot_o = s_r.bot;
endmodule : mcpw_dead

// >>> mcpw_top.sv
// Six-channel motor control modulator with register port and fault logic.
// How it works
// - Three complementary pairs or six independent outputs.
// - Edge-aligned or center-aligned counting selectable.
// - One shared 12-bit counter for all channels.
// - Resolution one tick edge, two ticks center.
// - Counter tick is bus clock over prescaler.
// - Complementary pairs get automatic dead time.
// - Output active level selectable by polarity bits.
// - Software can force each output level manually.
// - Pair width correction by current sense or software.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module mcpw_top (
  input wire logic mclk_i,
  input wire logic srst_i,
  input mcpw_pkg::mcpw_bus_type bus_i,
  output logic [7:0] rdata_o,
  input wire logic [1:0] fault_i,
  input wire logic [2:0] isense_i,
  output logic [5:0] pwm_o,
  output logic irq_o
);
  import mcpw_pkg::*;

  mcpw_state_type s_r;
  mcpw_state_type s_nxt;

  logic tick;
  logic bound;
  logic [PDIV_W-1:0] pmask;
  logic [NCH-1:0] raw;
  logic [NPAIR-1:0] pair_raw;
  logic [NPAIR-1:0] corr_sel;
  logic [NPAIR-1:0] dt_top;
  logic [NPAIR-1:0] dt_bot;
  logic [NCH-1:0] act;
  logic [NCH-1:0] pol;
  logic [1:0] fevt;
  logic [1:0] fprot;
  logic reload;
  logic [2:0] vidx;
  logic signed [15:0] cnt_s;

  // Prescaler: the counter advances once every 1, 2, 4 or 8 clocks.
  assign pmask = PDIV_W'((1 << s_r.presc) - 1);
  assign tick = s_r.run && ((s_r.pdiv & pmask) == pmask);

  // A period ends on the wrap in edge mode and at the valley in center
  // mode. While stopped every cycle counts as a boundary, so buffered
  // values, once permitted, and released faults take effect at once.
  always_comb begin
    bound = !s_r.run;
    if (tick) begin
      if (s_r.cfg[B_CFG_CENTER]) begin
        bound = (s_r.dir == DIR_DOWN) && (s_r.cnt == '0);
      end else begin
        bound = (CNT_W'(s_r.cnt + 1'b1) >= s_r.mod_act);
      end
    end
  end

  assign reload = bound && s_r.permit;

  // Signed compare: a negative value gives a 0 % pulse, a value at or
  // above the modulus a 100 % pulse. The rising half of a center period
  // counts 1 up to the modulus, so it compares inclusively and every
  // step of the value is worth two ticks.
  assign cnt_s = $signed({4'h0, s_r.cnt});

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      if (s_r.cfg[B_CFG_CENTER] && (s_r.dir == DIR_UP)) begin
        raw[i] = (s_r.cnt != '0) && $signed(s_r.val_act[i]) >= cnt_s;
      end else begin
        raw[i] = $signed(s_r.val_act[i]) > cnt_s;
      end
    end
  end

  // Each pair takes its first value while the selector is low and its
  // second while high, correcting the dead-time distortion per edge.
  always_comb begin
    for (int p = 0; p < NPAIR; p++) begin
      corr_sel[p] = s_r.cfg[B_CFG_ISENSE] ? s_r.ss2[p] : s_r.sw_corr[p];
      pair_raw[p] = corr_sel[p] ? raw[2*p+1] : raw[2*p];
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NPAIR; gp++) begin : g_pair
      mcpw_dead u_dead (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .dead_i(s_r.dead),
        .raw_i(pair_raw[gp]),
        .top_o(dt_top[gp]),
        .bot_o(dt_bot[gp])
      );
    end
  endgenerate

  assign fprot = {s_r.cfg[B_CFG_FP4], s_r.cfg[B_CFG_FP1]};
  assign fevt = s_r.fs2 & fprot;

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      pol[i] = (i % 2 == 0) ? s_r.cfg[B_CFG_NTOP] : s_r.cfg[B_CFG_NBOT];
      if (s_r.ovr_en) begin
        act[i] = s_r.ovr_lvl[i];
      end else if (!s_r.run) begin
        act[i] = 1'b0;
      end else if (s_r.cfg[B_CFG_INDEP]) begin
        act[i] = raw[i];
      end else begin
        act[i] = (i % 2 == 0) ? dt_top[i/2] : dt_bot[i/2];
      end
      // A held fault wins over software override.
      if ((s_r.fhold != 2'b00) || (fevt != 2'b00)) begin
        act[i] = 1'b0;
      end
    end
  end

  assign vidx = 3'((bus_i.addr - A_VAL0) >> 1);

  always_comb begin
    s_nxt = s_r;
    s_nxt.fs1 = fault_i;
    s_nxt.fs2 = s_r.fs1;
    s_nxt.ss1 = isense_i;
    s_nxt.ss2 = s_r.ss1;
    s_nxt.pwm = act ^ pol;

    // Prescaler and counter.
    if (!s_r.run) begin
      s_nxt.pdiv = '0;
      s_nxt.cnt = RST_CNT;
      s_nxt.dir = DIR_UP;
    end else begin
      s_nxt.pdiv = PDIV_W'(s_r.pdiv + 1'b1);
      if (tick) begin
        if (!s_r.cfg[B_CFG_CENTER]) begin
          s_nxt.cnt = bound ? RST_CNT : CNT_W'(s_r.cnt + 1'b1);
        end else if (s_r.dir == DIR_UP) begin
          if (s_r.cnt >= s_r.mod_act) begin
            s_nxt.dir = DIR_DOWN;
            s_nxt.cnt = CNT_W'(s_r.cnt - 1'b1);
          end else begin
            s_nxt.cnt = CNT_W'(s_r.cnt + 1'b1);
          end
        end else begin
          if (s_r.cnt == '0) begin
            s_nxt.dir = DIR_UP;
            s_nxt.cnt = CNT_W'(1);
          end else begin
            s_nxt.cnt = CNT_W'(s_r.cnt - 1'b1);
          end
        end
      end
    end

    // Buffered modulus and values move to the active copies only at a
    // period boundary while the permit bit is set, so a half-written pair of bytes is never used.
    if (reload) begin
      s_nxt.mod_act = s_r.mod_buf;
      s_nxt.val_act = s_r.val_buf;
      s_nxt.permit = 1'b0;
    end

    // Fault release: automatic mode waits for the pin, manual mode also
    // waits for the flag to be acknowledged; both at a boundary.
    for (int k = 0; k < 2; k++) begin
      if (bound && !s_r.fs2[k]) begin
        if (s_r.fctl[k == 0 ? B_F1MODE : B_F4MODE] || !s_r.flat[k]) begin
          s_nxt.fhold[k] = 1'b0;
        end
      end
    end

    // Register writes.
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        A_MAIN: begin
          s_nxt.run = bus_i.wdata[B_RUN];
          s_nxt.rie = bus_i.wdata[B_RIE];
          if (bus_i.wdata[B_PERMIT]) begin
            s_nxt.permit = 1'b1;
          end
          if (!bus_i.wdata[B_RFLAG]) begin
            s_nxt.rflag = 1'b0;
          end
        end
        A_SEC: begin
          s_nxt.presc = bus_i.wdata[1:0];
          s_nxt.sw_corr = bus_i.wdata[B_CORR +: 3];
        end
        A_FCTL: s_nxt.fctl = bus_i.wdata;
        A_FACK: begin
          if (bus_i.wdata[B_F1ACK]) begin
            s_nxt.flat[0] = 1'b0;
          end
          if (bus_i.wdata[B_F4ACK]) begin
            s_nxt.flat[1] = 1'b0;
          end
        end
        A_OVR: begin
          s_nxt.ovr_en = bus_i.wdata[B_OVREN];
          s_nxt.ovr_lvl = bus_i.wdata[5:0];
        end
        A_MODH: s_nxt.mod_buf[11:8] = bus_i.wdata[3:0];
        A_MODL: s_nxt.mod_buf[7:0] = bus_i.wdata;
        A_DEAD: s_nxt.dead = bus_i.wdata;
        A_CFG: s_nxt.cfg = bus_i.wdata;
        A_IMSK: s_nxt.imask = bus_i.wdata[2:0];
        default: begin
          if (bus_i.addr >= A_VAL0 && bus_i.addr <= A_VALN) begin
            if (bus_i.addr[0]) begin
              s_nxt.val_buf[vidx][7:0] = bus_i.wdata;
            end else begin
              s_nxt.val_buf[vidx][15:8] = bus_i.wdata;
            end
          end
        end
      endcase
    end

    // Read data, valid in the cycle after the strobe only.
    s_nxt.rdata = RST_REG;
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        A_MAIN: s_nxt.rdata = {2'b00, s_r.rie, s_r.rflag, 2'b00,
                               s_r.permit, s_r.run};
        A_SEC: s_nxt.rdata = {3'b000, s_r.sw_corr, s_r.presc};
        A_FCTL: s_nxt.rdata = s_r.fctl;
        A_FSTAT: s_nxt.rdata = {s_r.fs2[1], s_r.flat[1], 4'h0,
                                s_r.fs2[0], s_r.flat[0]};
        A_OVR: s_nxt.rdata = {1'b0, s_r.ovr_en, s_r.ovr_lvl};
        A_CNTH: s_nxt.rdata = {4'h0, s_r.cnt[11:8]};
        A_CNTL: s_nxt.rdata = s_r.cnt[7:0];
        A_MODH: s_nxt.rdata = {4'h0, s_r.mod_buf[11:8]};
        A_MODL: s_nxt.rdata = s_r.mod_buf[7:0];
        A_DEAD: s_nxt.rdata = s_r.dead;
        A_CFG: s_nxt.rdata = s_r.cfg;
        A_IST: s_nxt.rdata = {5'h00, s_r.ist};
        A_IMSK: s_nxt.rdata = {5'h00, s_r.imask};
        default: begin
          if (bus_i.addr >= A_VAL0 && bus_i.addr <= A_VALN) begin
            s_nxt.rdata = bus_i.addr[0] ? s_r.val_buf[vidx][7:0]
                                        : s_r.val_buf[vidx][15:8];
          end
        end
      endcase
      // Reading the interrupt status clears it; new events set below.
      if (bus_i.addr == A_IST) begin
        s_nxt.ist = 3'h0;
      end
    end

    // Hardware sets come last so an event in a clearing cycle survives.
    if (reload) begin
      s_nxt.rflag = 1'b1;
      if (s_r.rie) begin
        s_nxt.ist[I_RELOAD] = 1'b1;
      end
    end
    for (int k = 0; k < 2; k++) begin
      if (fevt[k]) begin
        s_nxt.flat[k] = 1'b1;
        s_nxt.fhold[k] = 1'b1;
        if (s_r.fctl[k == 0 ? B_F1IE : B_F4IE]) begin
          s_nxt.ist[I_FAULT1 + k] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      s_r <= '{run: 1'b0, permit: 1'b0, rflag: 1'b0, rie: 1'b0,
               presc: 2'b00, sw_corr: 3'b000, fctl: RST_REG,
               flat: 2'b00, fhold: 2'b00, ovr_en: 1'b0,
               ovr_lvl: 6'h00, mod_buf: RST_CNT, mod_act: RST_CNT,
               val_buf: '{default: RST_VAL},
               val_act: '{default: RST_VAL}, dead: RST_REG,
               cfg: RST_REG, ist: 3'h0, imask: 3'h0, pdiv: '0,
               cnt: RST_CNT, dir: DIR_UP, fs1: 2'b00, fs2: 2'b00,
               ss1: 3'h0, ss2: 3'h0, pwm: 6'h00, rdata: RST_REG};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rdata_o = s_r.rdata;
  assign pwm_o = s_r.pwm;
  assign irq_o = |(s_r.ist & s_r.imask);
endmodule : mcpw_top

// >>> mcpw_properties.sv
// Concurrent checks on the ports of the six-channel motor modulator.
`timescale 1ns/1ps
module mcpw_properties (
  input wire logic mclk_i,
  input wire logic srst_i,
  input mcpw_pkg::mcpw_bus_type bus_i,
  input wire logic [7:0] rdata_o,
  input wire logic [1:0] fault_i,
  input wire logic [2:0] isense_i,
  input wire logic [5:0] pwm_o,
  input wire logic irq_o
);
  import mcpw_pkg::*;
  logic [7:0] cfg_r, ovr_r, dead_r, msk_r;
  logic [3:0] quiet_r, flt_r;
  logic [5:0] pol;
  logic trip, comp;
  assign pol = {3{cfg_r[3], cfg_r[2]}};
  assign trip = (fault_i[0] & cfg_r[5]) | (fault_i[1] & cfg_r[6]);
  assign comp = !cfg_r[0] && cfg_r[3:2] == 2'b00 && !ovr_r[6];
  // Shadows follow config writes; checks wait until the writes settle.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      cfg_r <= 8'h00;
      ovr_r <= 8'h00;
      dead_r <= 8'h00;
      msk_r <= 8'h00;
      quiet_r <= 4'h0;
      flt_r <= 4'h0;
    end else begin
      if (bus_i.wr && bus_i.addr == A_CFG) cfg_r <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == A_OVR) ovr_r <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == A_DEAD) dead_r <= bus_i.wdata;
      if (bus_i.wr && bus_i.addr == A_IMSK) msk_r <= bus_i.wdata;
      quiet_r <= bus_i.wr ? 4'h0 : quiet_r + 4'(quiet_r != 4'hF);
      flt_r <= !trip ? 4'h0 : flt_r + 4'(flt_r != 4'hF);
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  a_rdata_idle: assert property (
    !$past(bus_i.rd) |-> rdata_o == 8'h00) else $error("Stray read data.");
  a_cnt_high_nibble: assert property (
    bus_i.rd && bus_i.addr == A_CNTH |=> rdata_o[7:4] == 4'h0)
    else $error("Counter wider than 12 bits.");
  a_ack_reads_zero: assert property (
    bus_i.rd && bus_i.addr == A_FACK |=> rdata_o == 8'h00)
    else $error("Acknowledge register read back nonzero.");
  a_fault_forces_off: assert property (
    flt_r > 4'd7 && !cfg_r[0] |-> pwm_o == pol)
    else $error("Outputs active during fault.");
  a_override_level: assert property (
    quiet_r > 4'd2 && ovr_r[6] && !cfg_r[0] && cfg_r[6:5] == 2'b00
    |-> pwm_o == (ovr_r[5:0] ^ pol)) else $error("Override level wrong.");
  a_pair_exclusive: assert property (
    quiet_r > 4'd4 && comp |-> (pwm_o[0] & pwm_o[1]) == 1'b0
    && (pwm_o[2] & pwm_o[3]) == 1'b0 && (pwm_o[4] & pwm_o[5]) == 1'b0)
    else $error("Top and bottom on together.");
  a_dead_gap: assert property (
    quiet_r > 4'd4 && comp && dead_r > 8'h01 && $fell(pwm_o[0])
    |-> !pwm_o[1] [*2]) else $error("Bottom on inside dead time.");
  a_irq_masked: assert property (
    msk_r[2:0] == 3'h0 && quiet_r > 4'd1 |-> !irq_o)
    else $error("Interrupt with all sources masked.");
  a_reset_quiet: assert property (
    $fell(srst_i) |-> pwm_o == 6'h00 && !irq_o)
    else $error("Outputs active after reset.");
endmodule : mcpw_properties
bind mcpw_top mcpw_properties u_props (.mclk_i(mclk_i), .srst_i(srst_i),
  .bus_i(bus_i), .rdata_o(rdata_o), .fault_i(fault_i),
  .isense_i(isense_i), .pwm_o(pwm_o), .irq_o(irq_o));

// >>> mcpw_stage.sv
// Power stage stand-in: fault sensors, current sense and pulse counters.
`timescale 1ns/1ps
module mcpw_stage (
  input wire logic mclk_i,
  input wire logic clr_i,
  input wire logic [1:0] trip_i,
  input wire logic [2:0] sense_i,
  input wire logic [5:0] pwm_i,
  output logic [1:0] fault_o = 2'b00,
  output logic [2:0] isense_o = 3'h0,
  output logic [5:0][15:0] hi_o = '0
);
  // Sensors answer one cycle late, like a comparator behind a filter.
  always @(posedge mclk_i) begin
    fault_o <= trip_i;
    isense_o <= sense_i;
    for (int i = 0; i < 6; i++) begin
      hi_o[i] <= clr_i ? 16'h0000 : hi_o[i] + 16'(pwm_i[i]);
    end
  end
endmodule : mcpw_stage

// >>> mcpw_top_tb.sv
// Self-checking bench for the six-channel motor modulator.
`timescale 1ns/1ps
module mcpw_top_tb;
  import mcpw_pkg::*;
  localparam int MOD = 10;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  mcpw_bus_type bus_i = '0;
  logic [7:0] rdata_o, rv;
  logic [1:0] trip = 2'b00, fault_i;
  logic [2:0] sense = 3'h0, isense_i;
  logic [5:0] pwm_o;
  logic irq_o;
  logic clr = 1'b1;
  logic [5:0][15:0] hi;
  logic [15:0] top0;
  int miscompares = 0;
  int n_checks = 0;
  initial begin
    forever #20 mclk_i = ~mclk_i;
  end
  mcpw_top dut (.mclk_i(mclk_i), .srst_i(srst_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .fault_i(fault_i), .isense_i(isense_i),
    .pwm_o(pwm_o), .irq_o(irq_o));
  mcpw_stage stage (.mclk_i(mclk_i), .clr_i(clr), .trip_i(trip),
    .sense_i(sense), .pwm_i(pwm_o), .fault_o(fault_i),
    .isense_o(isense_i), .hi_o(hi));
  task automatic results;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk_i);
    bus_i.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_i);
    bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk_i);
    bus_i.rd <= 1'b0;
    #1 rv = rdata_o;
  endtask : rd
  // Windows span whole periods, so the phase at the start does not matter.
  task automatic measure(input int cyc);
    repeat (100) @(posedge mclk_i);
    clr <= 1'b0;
    repeat (cyc) @(posedge mclk_i);
    clr <= 1'b1;
    #1;
  endtask : measure
  task automatic setup(input logic [7:0] cfg, input logic [7:0] pre,
                       input logic [15:0] v0, input logic [15:0] v1);
    wr(A_MAIN, 8'h00);
    wr(A_CFG, cfg);
    wr(A_SEC, pre);
    wr(A_MODH, 8'h00);
    wr(A_MODL, 8'(MOD));
    wr(A_VAL0, v0[15:8]);
    wr(A_VAL0 + 8'h01, v0[7:0]);
    wr(A_VAL0 + 8'h02, v1[15:8]);
    wr(A_VAL0 + 8'h03, v1[7:0]);
    wr(A_MAIN, 8'h02);
    wr(A_MAIN, 8'h01);
  endtask : setup
  task automatic t_regs;
    logic [7:0] adr [6] = '{A_MAIN, A_SEC, A_FCTL, A_FACK, A_CNTH, 8'h10};
    foreach (adr[i]) begin
      rd(adr[i]);
      check(16'(rv), 16'h0000);
    end
    wr(A_CNTH, 8'hFF);
    rd(A_CNTH);
    check(16'(rv), 16'h0000);
  endtask : t_regs
  task automatic t_edge;
    for (int p = 0; p < 4; p++) begin
      setup(8'h01, 8'(p), 16'h0003, 16'h0007);
      measure(2 * MOD * (1 << p));
      check(hi[0], 16'(6 * (1 << p)));
      check(hi[1], 16'(14 * (1 << p)));
    end
  endtask : t_edge
  task automatic t_center;
    setup(8'h03, 8'h00, 16'h0003, 16'h0007);
    measure(4 * MOD);
    check(hi[0], 16'h000C);
    check(hi[1], 16'h001C);
  endtask : t_center
  task automatic t_comp;
    wr(A_DEAD, 8'h02);
    setup(8'h00, 8'h00, 16'h0003, 16'h0007);
    measure(2 * MOD);
    top0 = hi[0];
    check(hi[0] + hi[1], 16'(2 * (MOD - 4)));
    wr(A_SEC, 8'h04);
    measure(2 * MOD);
    check(hi[0] - top0, 16'h0008);
    wr(A_SEC, 8'h00);
    wr(A_CFG, 8'h10);
    sense <= 3'h1;
    measure(2 * MOD);
    check(hi[0] - top0, 16'h0008);
    sense <= 3'h0;
    wr(A_CFG, 8'h04);
    measure(2 * MOD);
    check(hi[0], 16'(2 * MOD) - top0);
  endtask : t_comp
  task automatic t_override;
    wr(A_CFG, 8'h00);
    wr(A_OVR, 8'h55);
    repeat (3) @(posedge mclk_i);
    check(16'(pwm_o), 16'h0015);
    wr(A_CFG, 8'h0C);
    repeat (3) @(posedge mclk_i);
    check(16'(pwm_o), 16'h002A);
  endtask : t_override
  task automatic t_reload;
    wr(A_MAIN, 8'h23);
    repeat (20) @(posedge mclk_i);
    rd(A_MAIN);
    check(16'(rv), 16'h0031);
    rd(A_IST);
    check(16'(rv), 16'h0001);
    rd(A_IST);
    check(16'(rv), 16'h0000);
    wr(A_MAIN, 8'h01);
  endtask : t_reload
  task automatic t_fault;
    for (int f = 0; f < 2; f++) begin
      wr(A_CFG, 8'h20 << f);
      wr(A_FCTL, f ? 8'h80 : 8'h02);
      wr(A_IMSK, 8'h02 << f);
      trip <= 2'b01 << f;
      repeat (10) @(posedge mclk_i);
      check(16'(pwm_o), 16'h0000);
      check(16'(irq_o), 16'h0001);
      rd(A_FSTAT);
      check(16'(rv), f ? 16'h00C0 : 16'h0003);
      rd(A_IST);
      check(16'(rv & 8'h06), 16'(8'h02 << f));
      trip <= 2'b00;
      repeat (6) @(posedge mclk_i);
      rd(A_FSTAT);
      check(16'(rv), f ? 16'h0040 : 16'h0001);
      rd(A_IST);
      check(16'(rv & 8'h06), 16'(8'h02 << f));
      rd(A_IST);
      check(16'(rv), 16'h0000);
      wr(A_FACK, f ? 8'h40 : 8'h01);
      rd(A_FSTAT);
      check(16'(rv), 16'h0000);
      wr(A_IMSK, 8'h00);
      repeat (2) @(posedge mclk_i);
      check(16'(irq_o), 16'h0000);
    end
    wr(A_CFG, 8'h20);
    wr(A_FCTL, 8'h01);
    trip <= 2'b01;
    repeat (10) @(posedge mclk_i);
    check(16'(pwm_o), 16'h0000);
    trip <= 2'b00;
    repeat (30) @(posedge mclk_i);
    check(16'(pwm_o), 16'h0015);
    rd(A_FSTAT);
    check(16'(rv), 16'h0001);
  endtask : t_fault
  initial begin
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    t_regs;
    t_edge;
    t_center;
    t_comp;
    t_override;
    t_reload;
    t_fault;
    results;
  end
endmodule : mcpw_top_tb
